/* hw/uhp_device.sv */
// device end: pointer/data port, role control, frame number, dma
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module uhp_device (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  uhp_if.dev_mp                              bus,
  input  wire logic                          role_pin,
  input  wire logic                          clock_multiply_strap,
  input  wire logic                          sof_valid,
  input  wire logic [uhp_pkg::FRAME_W-1:0]   sof_frame,
  input  wire logic [uhp_pkg::EP_COUNT-1:0]  ep_buffer_sel,
  input  wire logic                          engine_irq,
  input  wire logic [uhp_pkg::DATA_W-1:0]    ep3_rd_data,
  output logic                               ep3_rd_take,
  output logic [uhp_pkg::DATA_W-1:0]         ep3_wr_data,
  output logic                               ep3_wr_valid,
  output logic                               host_mode,
  output logic                               polarity_swap,
  output logic                               use_multiplier,
  output logic                               usb_enable,
  output logic                               dma_busy
);
  import uhp_pkg::*;

  logic [7:0]             ptr_q;
  logic [7:0]             rd_q;
  logic [7:0]             ctrl1_q;
  logic [7:0]             cnt_lo_q;
  logic [7:0]             cnt_hi_q;
  logic [7:0]             frm_lo_q;
  logic [7:0]             frm_hi_q;
  logic [7:0]             ep3_wr_q;
  logic                   ep3_wr_valid_q;
  logic                   ep3_take_q;
  logic                   host_q;
  logic                   swap_q;
  logic                   mult_q;
  logic                   strap_done_q;
  logic                   irq_q;
  logic                   acc_q;
  logic                   dma_acc_q;
  logic [7:0]             mem [0:PTR_DEPTH-1];
  logic                   rd_act;
  logic                   wr_act;
  logic                   acc_first;
  logic                   reg_wr;
  logic                   dma_ok;
  logic                   dma_acc;
  logic                   dma_first;
  logic                   dma_rd_byte;
  logic                   dma_wr_byte;
  logic                   dma_start;
  logic                   cnt_zero;
  logic [7:0]             rd_mux;

  // strobes count only while chip select is low
  assign rd_act    = !bus.chip_select_n && !bus.read_strobe_n;
  assign wr_act    = !bus.chip_select_n && !bus.write_strobe_n;
  assign acc_first = (rd_act || wr_act) && !acc_q;
  assign reg_wr    = acc_first && wr_act && bus.port_select_line;

  // dma cycles are paced by acknowledge, honoured in peripheral mode
  assign dma_ok  = ctrl1_q[CTRL1_DMA_EN] && !host_q;
  assign dma_acc = !bus.dma_acknowledge_n && dma_ok &&
                   (!bus.read_strobe_n || !bus.write_strobe_n);
  assign dma_first   = dma_acc && !dma_acc_q && !cnt_zero;
  assign dma_rd_byte = dma_first && ctrl1_q[CTRL1_DMA_DIR] &&
                       !bus.read_strobe_n;
  assign dma_wr_byte = dma_first && !ctrl1_q[CTRL1_DMA_DIR] &&
                       !bus.write_strobe_n;
  assign dma_start   = reg_wr && ptr_q == ADDR_CNT_HI &&
                       ctrl1_q[CTRL1_DMA_EN] && !host_q;

  // byte count loads from both halves on the count-high write
  uhp_byte_counter #(
    .W (DMA_COUNT_W)
  ) u_count (
    .clk        (pclk),
    .rst_n      (presetn),
    .clear      (!bus.reset_n || !dma_ok),
    .load       (dma_start),
    .load_value ({bus.bus_data, cnt_lo_q}),
    .dec        (dma_rd_byte || dma_wr_byte),
    .count      (),
    .zero       (cnt_zero)
  );

  // access edge trackers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q     <= 1'h0;
      dma_acc_q <= 1'h0;
    end else begin
      acc_q     <= rd_act || wr_act;
      dma_acc_q <= dma_acc;
    end
  end

  // pointer, control and count registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q    <= REG_RESET;
      ctrl1_q  <= REG_RESET;
      cnt_lo_q <= REG_RESET;
      cnt_hi_q <= REG_RESET;
      host_q   <= 1'h0;
      swap_q   <= 1'h0;
    end else if (!bus.reset_n) begin
      ptr_q    <= REG_RESET;
      ctrl1_q  <= REG_RESET;
      cnt_lo_q <= REG_RESET;
      cnt_hi_q <= REG_RESET;
      host_q   <= 1'h0;
      swap_q   <= 1'h0;
    end else if (!strap_done_q) begin
      host_q <= !role_pin;
    end else if (acc_first && wr_act && !bus.port_select_line) begin
      ptr_q <= bus.bus_data;
    end else if (reg_wr) begin
      case (ptr_q)
        ADDR_CTRL1:  ctrl1_q <= bus.bus_data;
        ADDR_ROLE: begin
          host_q <= bus.bus_data[ROLE_HOST_BIT];
          swap_q <= bus.bus_data[ROLE_SWAP_BIT];
        end
        ADDR_CNT_LO: cnt_lo_q <= bus.bus_data;
        ADDR_CNT_HI: cnt_hi_q <= bus.bus_data;
        default: ;
      endcase
    end
  end

  // straps are caught on the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_q <= 1'h0;
      mult_q       <= 1'h0;
    end else if (!bus.reset_n) begin
      strap_done_q <= 1'h0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'h1;
      mult_q       <= clock_multiply_strap;
    end
  end

  // frame number, refreshed only by received sof
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frm_lo_q <= REG_RESET;
      frm_hi_q <= REG_RESET;
    end else if (sof_valid) begin
      frm_lo_q <= {sof_frame[FRM_LO_BITS-1:0], 1'h0};
      frm_hi_q <= {sof_frame[FRAME_W-1:FRM_LO_BITS], 4'h0};
    end
  end

  // general buffer space behind the pointer
  always_ff @(posedge pclk) begin
    if (reg_wr && bus.reset_n) begin
      mem[ptr_q] <= bus.bus_data;
    end
  end

  // read selection; frame registers ignore writes above
  always_comb begin
    case (ptr_q)
      ADDR_CTRL1:   rd_mux = ctrl1_q;
      ADDR_CUR_BUF: rd_mux = {4'h0, ep_buffer_sel};
      ADDR_ROLE:    rd_mux = {host_q, swap_q, 6'h00};
      ADDR_FRM_LO:  rd_mux = frm_lo_q;
      ADDR_FRM_HI:  rd_mux = frm_hi_q;
      ADDR_CNT_LO:  rd_mux = cnt_lo_q;
      ADDR_CNT_HI:  rd_mux = cnt_hi_q;
      default:      rd_mux = mem[ptr_q];
    endcase
  end

  // read byte register, also the endpoint three dma source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= REG_RESET;
    end else if (dma_rd_byte) begin
      rd_q <= ep3_rd_data;
    end else if (acc_first && rd_act) begin
      rd_q <= bus.port_select_line ? rd_mux : ptr_q;
    end
  end

  // endpoint three dma sink and source pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep3_wr_q       <= REG_RESET;
      ep3_wr_valid_q <= 1'h0;
      ep3_take_q     <= 1'h0;
    end else begin
      ep3_wr_valid_q <= dma_wr_byte;
      ep3_take_q     <= dma_rd_byte;
      if (dma_wr_byte) begin
        ep3_wr_q <= bus.bus_data;
      end
    end
  end

  // interrupt request passes through one register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'h0;
    end else begin
      irq_q <= engine_irq && bus.reset_n;
    end
  end

  // bus outputs; request is withdrawn for the whole acknowledge window
  assign bus.dev_data      = rd_q;
  assign bus.dev_data_oe   = rd_act ||
                             (dma_acc && !bus.read_strobe_n);
  assign bus.dma_request_n = !(dma_ok && !cnt_zero &&
                               bus.dma_acknowledge_n);
  assign bus.interrupt_request = irq_q;
  assign ep3_rd_take    = ep3_take_q;
  assign ep3_wr_data    = ep3_wr_q;
  assign ep3_wr_valid   = ep3_wr_valid_q;
  assign host_mode      = host_q;
  assign polarity_swap  = swap_q;
  assign use_multiplier = mult_q;
  assign usb_enable     = ctrl1_q[CTRL1_USB_EN];
  assign dma_busy       = !cnt_zero;
endmodule

/* pkg/uhp_pkg.sv */
// shared constants and types for the host port and its controller
package uhp_pkg;
  localparam int DATA_W      = 8;
  localparam int FRAME_W     = 11;
  localparam int EP_COUNT    = 4;
  localparam int DMA_COUNT_W = 16;
  localparam int PTR_DEPTH   = 256;
  // device register offsets, reached through the pointer
  localparam logic [7:0] ADDR_CTRL1   = 8'h05;
  localparam logic [7:0] ADDR_CUR_BUF = 8'h0E;
  localparam logic [7:0] ADDR_ROLE    = 8'h0F;
  localparam logic [7:0] ADDR_FRM_LO  = 8'h15;
  localparam logic [7:0] ADDR_FRM_HI  = 8'h16;
  localparam logic [7:0] ADDR_CNT_LO  = 8'h35;
  localparam logic [7:0] ADDR_CNT_HI  = 8'h36;
  // field positions
  localparam int ROLE_HOST_BIT = 7;
  localparam int ROLE_SWAP_BIT = 6;
  localparam int CTRL1_USB_EN  = 0;
  localparam int CTRL1_DMA_EN  = 1;
  localparam int CTRL1_DMA_DIR = 2;
  localparam int FRM_LO_BITS   = 7;
  localparam int FRM_HI_LSB    = 4;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] BUS_IDLE_DATA = 8'hFF;
  // strobe timing at the pclk rate
  localparam int CLK_PERIOD_NS = 100;
  localparam int STROBE_MIN_NS = 85;
  localparam int RECOVER_MIN_NS = 85;
  localparam int STROBE_MIN_CYC =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC =
    (RECOVER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // one extra strobe cycle lets the device register its read byte
  localparam int HOST_STROBE_CYC = STROBE_MIN_CYC + 1;
  // controller apb map
  localparam logic [11:0] APB_CMD    = 12'h000;
  localparam logic [11:0] APB_STATUS = 12'h004;
  localparam logic [11:0] APB_RDATA  = 12'h008;
  localparam logic [11:0] APB_CTRL   = 12'h00C;
  localparam int CMD_PORT_BIT = 8;
  localparam int CMD_READ_BIT = 9;
  localparam int CMD_DMA_BIT  = 10;
  localparam int CMD_W        = 11;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_DRQ_BIT   = 1;
  localparam int ST_IRQ_BIT   = 2;
  localparam int CTRL_RUN_BIT = 0;
  typedef enum logic [1:0] {
    UHP_IDLE    = 2'b00,
    UHP_SETUP   = 2'b01,
    UHP_STROBE  = 2'b11,
    UHP_RECOVER = 2'b10
  } uhp_state_e;
endpackage

/* pkg/uhp_if.sv */
// strobed 8-bit port between controller and device
`timescale 1ns/1ns
interface uhp_if;
  logic       chip_select_n;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic       port_select_line;
  logic       dma_acknowledge_n;
  logic       dma_request_n;
  logic       interrupt_request;
  logic       reset_n;
  logic [7:0] ctl_data;
  logic       ctl_data_oe;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  logic [7:0] bus_data;

  // resolved data wire, pulled high when nobody drives
  assign bus_data = ctl_data_oe ? ctl_data :
                    dev_data_oe ? dev_data : 8'hFF;

  modport dev_mp (
    input  chip_select_n, read_strobe_n, write_strobe_n,
    input  port_select_line, dma_acknowledge_n, reset_n, bus_data,
    output dma_request_n, interrupt_request, dev_data, dev_data_oe
  );
  modport ctl_mp (
    output chip_select_n, read_strobe_n, write_strobe_n,
    output port_select_line, dma_acknowledge_n, reset_n,
    output ctl_data, ctl_data_oe,
    input  dma_request_n, interrupt_request, bus_data
  );
endinterface

/* hw/uhp_byte_counter.sv */
// loadable down counter for the dma byte count
`timescale 1ns/1ns
module uhp_byte_counter #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  input  wire logic         dec,
  output logic [W-1:0]      count,
  output logic              zero
);
  logic [W-1:0] count_q;

  // clear beats load, load beats decrement
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (clear) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_value;
    end else if (dec && count_q != '0) begin
      count_q <= count_q - W'(1);
    end
  end

  assign count = count_q;
  assign zero  = (count_q == '0);
endmodule

/* hw/uhp_host.sv */
// controller end: apb-programmed strobe sequencer and dma acknowledge
`timescale 1ns/1ns
module uhp_host #(
  parameter int STROBE_CYC = uhp_pkg::HOST_STROBE_CYC,
  parameter int RECOV_CYC  = uhp_pkg::RECOVER_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  uhp_if.ctl_mp            bus
);
  import uhp_pkg::*;

  uhp_state_e          state_q;
  logic [CMD_W-1:0]    cmd_q;
  logic [7:0]          rdata_q;
  logic                run_q;
  logic [3:0]          cnt_q;
  logic [31:0]         prdata_q;
  logic                apb_wr;
  logic                mapped;
  logic                active;
  logic                is_dma;

  assign mapped = paddr == APB_CMD || paddr == APB_STATUS ||
                  paddr == APB_RDATA || paddr == APB_CTRL;
  assign apb_wr = psel && penable && pwrite && mapped;
  assign active = state_q == UHP_SETUP || state_q == UHP_STROBE;
  assign is_dma = cmd_q[CMD_DMA_BIT];

  // read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable) begin
      case (paddr)
        APB_CMD:    prdata_q <= {21'h0, cmd_q};
        APB_STATUS: prdata_q <= {29'h0,
                                 bus.interrupt_request,
                                 !bus.dma_request_n,
                                 state_q != UHP_IDLE};
        APB_RDATA:  prdata_q <= {24'h000000, rdata_q};
        APB_CTRL:   prdata_q <= {31'h0, run_q};
        default:    prdata_q <= 32'h00000000;
      endcase
    end
  end

  // device reset control, released by default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'h1;
    end else if (apb_wr && paddr == APB_CTRL) begin
      run_q <= pwdata[CTRL_RUN_BIT];
    end
  end

  // command register, accepted only while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= '0;
    end else if (apb_wr && paddr == APB_CMD && state_q == UHP_IDLE) begin
      cmd_q <= pwdata[CMD_W-1:0];
    end
  end

  // cycle sequencer: setup, strobe, recovery
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= UHP_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      case (state_q)
        UHP_IDLE: begin
          if (apb_wr && paddr == APB_CMD) begin
            state_q <= UHP_SETUP;
          end
        end
        UHP_SETUP: begin
          state_q <= UHP_STROBE;
          cnt_q   <= 4'(STROBE_CYC - 1);
        end
        UHP_STROBE: begin
          if (cnt_q == 4'h0) begin
            state_q <= UHP_RECOVER;
            cnt_q   <= 4'(RECOV_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        UHP_RECOVER: begin
          if (cnt_q == 4'h0) begin
            state_q <= UHP_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: state_q <= UHP_IDLE;
      endcase
    end
  end

  // read byte captured on the last strobe edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 8'h00;
    end else if (state_q == UHP_STROBE && cnt_q == 4'h0 &&
                 cmd_q[CMD_READ_BIT]) begin
      rdata_q <= bus.bus_data;
    end
  end

  // pin drive; dma cycles use acknowledge instead of chip select
  assign bus.chip_select_n     = !(active && !is_dma);
  assign bus.dma_acknowledge_n = !(active && is_dma);
  assign bus.read_strobe_n     = !(state_q == UHP_STROBE &&
                                   cmd_q[CMD_READ_BIT]);
  assign bus.write_strobe_n    = !(state_q == UHP_STROBE &&
                                   !cmd_q[CMD_READ_BIT]);
  assign bus.port_select_line  = cmd_q[CMD_PORT_BIT];
  assign bus.ctl_data          = cmd_q[7:0];
  assign bus.ctl_data_oe       = active && !cmd_q[CMD_READ_BIT];
  assign bus.reset_n           = run_q;
  assign pready                = psel && penable;
  assign pslverr               = psel && penable && !mapped;
  assign prdata                = prdata_q;
endmodule

/* bench/uhp_checker.sv */
// interface checker for the strobed port between controller and device
`timescale 1ns/1ns
module uhp_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic port_select_line,
  input wire logic dma_acknowledge_n,
  input wire logic dma_request_n,
  input wire logic reset_n,
  input wire logic ctl_data_oe,
  input wire logic dev_data_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // device drives only when selected and read strobe is low
  AST_DEV_DRIVE_NEEDS_SELECT: assert property (
    dev_data_oe |-> !read_strobe_n && (!chip_select_n || !dma_acknowledge_n))
    else $error("device drives data without select and read strobe");
  AST_NO_BUS_FIGHT: assert property (!(ctl_data_oe && dev_data_oe))
    else $error("both ends drive the data bus");
  AST_REQ_HIGH_IN_ACK: assert property (
    !dma_acknowledge_n |-> dma_request_n)
    else $error("dma request stays low during acknowledge");
  AST_CS_SETUP: assert property (
    $fell(chip_select_n) |-> read_strobe_n && write_strobe_n)
    else $error("strobe low in the select setup cycle");
  AST_WR_STROBE_LEN: assert property (
    $fell(write_strobe_n) |=> !write_strobe_n ##1 write_strobe_n)
    else $error("write strobe length wrong");
  AST_RD_STROBE_LEN: assert property (
    $fell(read_strobe_n) |=> !read_strobe_n ##1 read_strobe_n)
    else $error("read strobe length wrong");
  // port select may not move while the device is selected
  AST_PORT_STABLE: assert property (
    !chip_select_n && !$past(chip_select_n) |-> $stable(port_select_line))
    else $error("port select changed inside a cycle");
  AST_RECOVER_IDLE: assert property (
    $rose(write_strobe_n) || $rose(read_strobe_n)
      |-> chip_select_n && dma_acknowledge_n)
    else $error("select held through recovery");
  AST_REQ_IN_RESET: assert property (
    !reset_n && !$past(reset_n) |-> dma_request_n)
    else $error("dma request low while device held in reset");

  // main traffic kinds
  COV_DMA_WRITE: cover property ($fell(write_strobe_n) && !dma_acknowledge_n);
  COV_DMA_READ: cover property ($fell(read_strobe_n) && !dma_acknowledge_n);
  COV_REG_READ: cover property ($fell(read_strobe_n) && !chip_select_n);
endmodule

/* bench/test_usb_ctrl_host_port_dma_regs.sv */
// self-checking bench for the controller and device pair
`timescale 1ns/1ns
module test_usb_ctrl_host_port_dma_regs;
  import uhp_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic [7:0] v;
    logic [7:0] e;
    logic [1:0] m;
  } uhp_row_s;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic        role_pin, sof_valid, engine_irq, ep3_rd_take, ep3_wr_valid;
  logic [10:0] sof_frame;
  logic [3:0]  ep_buffer_sel;
  logic [7:0]  ep3_rd_data, ep3_wr_data, last_wr;
  logic        host_mode, polarity_swap, use_multiplier, usb_enable;
  logic        dma_busy;
  int          failures = 0;
  int          tests_run = 0;
  int          wr_seen = 0;
  int          take_seen = 0;
  logic        cm_strap;
  uhp_row_s    rows [6];

  uhp_if u_if ();
  uhp_host i_uhp_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(u_if));
  uhp_device i_uhp_device (.pclk(pclk), .presetn(presetn), .bus(u_if),
    .role_pin(role_pin), .clock_multiply_strap(cm_strap),
    .sof_valid(sof_valid), .sof_frame(sof_frame),
    .ep_buffer_sel(ep_buffer_sel), .engine_irq(engine_irq),
    .ep3_rd_data(ep3_rd_data), .ep3_rd_take(ep3_rd_take),
    .ep3_wr_data(ep3_wr_data), .ep3_wr_valid(ep3_wr_valid),
    .host_mode(host_mode), .polarity_swap(polarity_swap),
    .use_multiplier(use_multiplier), .usb_enable(usb_enable),
    .dma_busy(dma_busy));
  uhp_checker i_uhp_checker (.pclk(pclk), .presetn(presetn),
    .chip_select_n(u_if.chip_select_n), .read_strobe_n(u_if.read_strobe_n),
    .write_strobe_n(u_if.write_strobe_n),
    .port_select_line(u_if.port_select_line),
    .dma_acknowledge_n(u_if.dma_acknowledge_n),
    .dma_request_n(u_if.dma_request_n), .reset_n(u_if.reset_n),
    .ctl_data_oe(u_if.ctl_data_oe), .dev_data_oe(u_if.dev_data_oe));

  // clock at 10 MHz
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // record bytes the device hands to endpoint three
  always @(posedge pclk) begin
    if (ep3_wr_valid === 1'b1) begin
      wr_seen <= wr_seen + 1;
      last_wr <= ep3_wr_data;
    end
    if (ep3_rd_take === 1'b1) begin
      take_seen <= take_seen + 1;
    end
  end

  task automatic finish_test;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      failures++;
      finish_test();
    end
  endtask

  // issue a port command and wait until the controller is idle again
  task automatic cmd(input logic [31:0] c);
    int n;
    apb(1'b1, APB_CMD, c);
    for (n = 0; n < 50; n++) begin
      apb(1'b0, APB_STATUS, 32'h0);
      if (rd[ST_BUSY_BIT] === 1'b0) break;
    end
    if (n == 50) begin
      failures++;
      finish_test();
    end
  endtask

  task automatic dev_wr(input logic [7:0] r, input logic [7:0] v);
    cmd({24'h0, r});
    cmd({23'h0, 1'b1, v});
  endtask

  task automatic dev_rd(input logic [7:0] r);
    cmd({24'h0, r});
    cmd(32'h0000_0300);
    apb(1'b0, APB_RDATA, 32'h0);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    role_pin = 1'b1;
    cm_strap = 1'b1;
    sof_valid = 1'b0;
    sof_frame = 11'h000;
    ep_buffer_sel = 4'hA;
    engine_irq = 1'b0;
    ep3_rd_data = 8'h3C;
    rows = '{'{ADDR_ROLE, 8'hC0, 8'hC0, 2'b11},
             '{ADDR_ROLE, 8'h7F, 8'h40, 2'b01},
             '{ADDR_FRM_LO, 8'hFF, 8'h46, 2'b01},
             '{ADDR_FRM_HI, 8'h00, 8'hB0, 2'b01},
             '{ADDR_CUR_BUF, 8'h05, 8'h0A, 2'b01},
             '{ADDR_CNT_LO, 8'h12, 8'h12, 2'b01}};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, host_mode}, 32'h0);
    chk({31'h0, use_multiplier}, 32'h1);
    chk({31'h0, u_if.dma_request_n}, 32'h1);
    // one start-of-frame carrying frame 0x5A3
    sof_frame <= 11'h5A3;
    sof_valid <= 1'b1;
    @(posedge pclk);
    sof_valid <= 1'b0;
    // register rows: write, read back, check role outputs
    foreach (rows[i]) begin
      dev_wr(rows[i].a, rows[i].v);
      dev_rd(rows[i].a);
      chk(rd, {24'h0, rows[i].e});
      chk({30'h0, host_mode, polarity_swap}, {30'h0, rows[i].m});
    end
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    engine_irq <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, u_if.interrupt_request}, 32'h1);
    apb(1'b0, APB_STATUS, 32'h0);
    chk({31'h0, rd[ST_IRQ_BIT]}, 32'h1);
    engine_irq <= 1'b0;
    // count-high write with dma disabled starts nothing
    dev_wr(ADDR_CTRL1, 8'h01);
    dev_wr(ADDR_CNT_LO, 8'h01);
    dev_wr(ADDR_CNT_HI, 8'h00);
    chk({31'h0, u_if.dma_request_n}, 32'h1);
    // two dma bytes into the device, high count zero
    dev_wr(ADDR_CTRL1, 8'h03);
    dev_wr(ADDR_CNT_LO, 8'h02);
    dev_wr(ADDR_CNT_HI, 8'h00);
    chk({31'h0, u_if.dma_request_n}, 32'h0);
    chk({31'h0, dma_busy}, 32'h1);
    chk({31'h0, rd[ST_DRQ_BIT]}, 32'h1);
    cmd(32'h0000_04A5);
    cmd(32'h0000_045A);
    chk(wr_seen, 32'd2);
    chk({24'h0, last_wr}, 32'h5A);
    chk({31'h0, u_if.dma_request_n}, 32'h1);
    // one dma byte read out of the device
    dev_wr(ADDR_CTRL1, 8'h07);
    dev_wr(ADDR_CNT_LO, 8'h01);
    dev_wr(ADDR_CNT_HI, 8'h00);
    cmd(32'h0000_0600);
    apb(1'b0, APB_RDATA, 32'h0);
    chk(rd, 32'h3C);
    chk({31'h0, dma_busy}, 32'h0);
    chk(take_seen, 32'd1);
    // host mode refuses dma
    dev_wr(ADDR_ROLE, 8'h80);
    dev_wr(ADDR_CTRL1, 8'h03);
    dev_wr(ADDR_CNT_LO, 8'h01);
    dev_wr(ADDR_CNT_HI, 8'h00);
    chk({31'h0, u_if.dma_request_n}, 32'h1);
    // device reset through the controller clears its pointer, control, count and role registers
    apb(1'b1, APB_CTRL, 32'h0);
    cm_strap <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(1'b1, APB_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    chk({30'h0, host_mode, usb_enable}, 32'h0);
    chk({31'h0, use_multiplier}, 32'h0);
    dev_rd(ADDR_ROLE);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule
